// *** rtl/mmoa_core.sv ***
// module: operand address decoder, register banks, internal ram and special registers
`timescale 1ns/100ps

// Notes on behaviour
// RULE1: source pin high: fetch on-chip up to 4095, external above.
// RULE2: source pin low: every fetch goes to external program memory.
// RULE3: fetch answer latency is the same for on-chip and external.
// RULE4: software should leave on-chip byte 4095 empty to avoid prefetch of 4096.
// RULE5: after reset the program counter is zero.
// RULE6: addresses 0003 to 0042 are marked as interrupt entry area.
// RULE7: program counter is 16 bits; fetches never touch data spaces.
// RULE8: external data move accesses the 64K external data space.
// RULE9: ram bytes 0 to 31 hold four banks of eight registers.
// RULE10: register number from opcode bits 2:0, bank from status bits 4:3.
// RULE11: ram populated at 0 to 127; 128 to 255 unpopulated.
// RULE12: 8-bit loadable stack pointer; calls save program counter on stack.
// RULE13: push and pop take any direct byte, ram or special register.
// RULE14: special registers live at 128 to 255.
// RULE15: direct byte msb selects ram (low half) or special registers (high half).
// RULE16: bit address n is bit n mod 8 of byte 20H plus n div 8.
// RULE17: high bit addresses: upper five bits pick register, lower three bit.
// RULE18: only special registers at multiples of eight are bit addressable.
// RULE19: base plus index reads program byte at pointer or pc plus accumulator.
// RULE20: indirect address from working register 0 or 1 by opcode bit 0.
// RULE21: exactly one access strobe per operand.
module mmoa_core
  import mmoa_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // program source pin
  input wire logic program_source_select_in,
  // operand request
  input wire mmoa_req_s req_in,
  // operand answer and state
  output mmoa_rsp_s rsp_out,
  output logic [15:0] program_counter_out,
  output logic source_onchip_out
);

  mmoa_state_s q;
  mmoa_state_s d;

  // locate a special register by byte address: {hit, index}
  function automatic logic [5:0] sfr_find(input logic [7:0] a);
    logic [5:0] r;
    r = '0;
    for (int i = 0; i < MMOA_SFR_N; i++) begin
      if (MMOA_SFR_ADDR[i] == a) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction : sfr_find

  // read internal ram; unpopulated upper half reads zero
  function automatic logic [7:0] get_ram(input mmoa_state_s s, input logic [7:0] a);
    logic [7:0] v;
    v = '0;
    if (!a[7]) begin
      v = s.ram[a[MMOA_RAM_AW-1:0]]; // [RULE11]
    end
    return v;
  endfunction : get_ram

  // write internal ram; writes to the unpopulated half are dropped
  function automatic mmoa_state_s put_ram(input mmoa_state_s s, input logic [7:0] a, input logic [7:0] v);
    mmoa_state_s t;
    t = s;
    if (!a[7]) begin
      t.ram[a[MMOA_RAM_AW-1:0]] = v; // [RULE11]
    end
    return t;
  endfunction : put_ram

  // direct byte read: msb picks ram or special register
  function automatic logic [7:0] get_byte(input mmoa_state_s s, input logic [7:0] a);
    logic [5:0] f;
    logic [7:0] v;
    f = sfr_find(a);
    v = '0;
    if (!a[7]) begin
      v = s.ram[a[MMOA_RAM_AW-1:0]]; // [RULE15]
    end else if (f[5]) begin
      v = s.sfr[f[4:0]]; // [RULE14]
    end
    return v;
  endfunction : get_byte

  // direct byte write; unmapped special addresses are ignored
  function automatic mmoa_state_s put_byte(input mmoa_state_s s, input logic [7:0] a, input logic [7:0] v);
    mmoa_state_s t;
    logic [5:0] f;
    t = s;
    f = sfr_find(a);
    if (!a[7]) begin
      t.ram[a[MMOA_RAM_AW-1:0]] = v; // [RULE15]
    end else if (f[5]) begin
      t.sfr[f[4:0]] = v; // [RULE14]
    end
    return t;
  endfunction : put_byte

  // program memory strobe for a fetch-type address
  function automatic mmoa_strobe_s prog_strobe(input logic onchip, input logic [15:0] a);
    mmoa_strobe_s s;
    s = '0;
    if (onchip && (a <= MMOA_ONCHIP_TOP)) begin
      s.prog_int = 1'b1; // [RULE1]
    end else begin
      s.prog_ext = 1'b1; // [RULE2]
    end
    return s;
  endfunction : prog_strobe

  logic [1:0] bank;
  logic [7:0] ri_val;
  logic [7:0] sp;
  logic [7:0] acc;
  logic [15:0] table_base_pointer;
  logic [7:0] bit_byte_addr;
  logic [7:0] cur;
  logic [7:0] nb;

  // bank, pointer and accumulator views of the register file
  assign bank = q.sfr[MMOA_I_PSW][MMOA_BANK_HI:MMOA_BANK_LO]; // [RULE10]
  assign ri_val = get_ram(q, {3'b000, bank, 2'b00, req_in.opcode[0]}); // [RULE20] [RULE9]
  assign sp = q.sfr[MMOA_I_SP];
  assign acc = q.sfr[MMOA_I_ACC];
  assign table_base_pointer = {q.sfr[MMOA_I_DPH], q.sfr[MMOA_I_DPL]};
  assign bit_byte_addr = req_in.operand[7] ? {req_in.operand[7:3], 3'b000}
                                           : MMOA_BIT_RAM_BASE + {4'h0, req_in.operand[6:3]}; // [RULE16] [RULE17] [RULE18]

  // next state: pin filter, operand decode and register file update
  always_comb begin
    d = q;
    d.rsp = '0;
    cur = '0;
    nb = '0;
    d.sync = {q.sync[1:0], program_source_select_in};
    if (q.sync[2] == q.sync[1]) begin
      d.src_onchip = q.sync[2];
    end
    if (req_in.valid) begin
      d.rsp.valid = 1'b1; // one answer cycle for every kind except MODE_LOAD_PC [RULE3]
      case (req_in.mode)
        MODE_FETCH: begin
          d.rsp.strobe = prog_strobe(q.src_onchip, q.pc); // [RULE1] [RULE2] [RULE7]
          d.rsp.addr = q.pc;
          d.rsp.reserved_area = (q.pc >= MMOA_VEC_LO) && (q.pc <= MMOA_VEC_HI); // [RULE6]
          d.pc = q.pc + MMOA_PC_STEP; // [RULE7]
        end
        MODE_LOAD_PC: begin
          d.rsp.valid = 1'b0;
          d.pc = req_in.target;
        end
        MODE_EXT_DATA: begin
          d.rsp.strobe.ext_data = 1'b1; // [RULE8]
          d.rsp.addr = req_in.opcode[1] ? {8'h00, ri_val} : table_base_pointer; // [RULE8]
        end
        MODE_REG: begin
          cur = {3'b000, bank, req_in.opcode[2:0]}; // [RULE10] [RULE9]
          d.rsp.strobe.int_ram = 1'b1;
          d.rsp.addr = {8'h00, cur};
          d.rsp.rdata = get_ram(q, cur);
          if (req_in.write) begin
            d = put_ram(d, cur, req_in.wdata);
          end
        end
        MODE_DIR_BYTE: begin
          cur = req_in.operand;
          d.rsp.strobe.sfr = cur[7]; // [RULE15]
          d.rsp.strobe.int_ram = !cur[7]; // [RULE15]
          d.rsp.addr = {8'h00, cur};
          d.rsp.rdata = get_byte(q, cur);
          if (req_in.write) begin
            d = put_byte(d, cur, req_in.wdata);
          end
        end
        MODE_DIR_BIT: begin
          cur = get_byte(q, bit_byte_addr);
          nb = cur;
          nb[req_in.operand[2:0]] = req_in.wdata[0]; // [RULE16] [RULE17]
          d.rsp.strobe.sfr = req_in.operand[7];
          d.rsp.strobe.int_ram = !req_in.operand[7];
          d.rsp.addr = {8'h00, bit_byte_addr};
          d.rsp.bitpos = req_in.operand[2:0];
          d.rsp.rdata = cur;
          if (req_in.write) begin
            d = put_byte(d, bit_byte_addr, nb);
          end
        end
        MODE_INDIRECT: begin
          d.rsp.strobe.int_ram = 1'b1; // [RULE20]
          d.rsp.addr = {8'h00, ri_val};
          d.rsp.rdata = get_ram(q, ri_val);
          if (req_in.write) begin
            d = put_ram(d, ri_val, req_in.wdata);
          end
        end
        MODE_BASE_INDEX: begin
          d.rsp.addr = (req_in.opcode[4] ? table_base_pointer : q.pc) + {8'h00, acc}; // [RULE19]
          d.rsp.strobe = prog_strobe(q.src_onchip, d.rsp.addr); // [RULE19]
        end
        MODE_PUSH: begin
          cur = sp + MMOA_SP_STEP;
          nb = get_byte(q, req_in.operand); // [RULE13]
          d.sfr[MMOA_I_SP] = cur; // [RULE12]
          d = put_ram(d, cur, nb);
          d.rsp.strobe.int_ram = 1'b1;
          d.rsp.addr = {8'h00, cur};
          d.rsp.rdata = nb;
        end
        MODE_POP: begin
          nb = get_ram(q, sp);
          d.sfr[MMOA_I_SP] = sp - MMOA_SP_STEP; // [RULE12]
          d = put_byte(d, req_in.operand, nb); // [RULE13]
          d.rsp.strobe.int_ram = 1'b1;
          d.rsp.addr = {8'h00, sp};
          d.rsp.rdata = nb;
        end
        MODE_CALL_SAVE: begin
          cur = sp + MMOA_SP_STEP;
          d = put_ram(d, cur, q.pc[7:0]); // [RULE12]
          d = put_ram(d, cur + MMOA_SP_STEP, q.pc[15:8]); // [RULE12]
          d.sfr[MMOA_I_SP] = cur + MMOA_SP_STEP;
          d.rsp.strobe.int_ram = 1'b1;
          d.rsp.addr = {8'h00, cur};
        end
        default: begin
          d.rsp.valid = 1'b0;
        end
      endcase
    end
  end

  // state register with enable freeze
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      q.sync <= '0;
      q.src_onchip <= 1'b0;
      q.pc <= MMOA_RESET_PC; // [RULE5]
      q.sfr <= MMOA_SFR_RST;
      q.ram <= '0;
      q.rsp <= '0;
    end else if (clk_en_in) begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign rsp_out = q.rsp;
  assign program_counter_out = q.pc;
  assign source_onchip_out = q.src_onchip;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  logic go;
  assign go = clk_en_in && req_in.valid;

  sequence s_fetch_on;
    go && (req_in.mode == MODE_FETCH) && q.src_onchip && (q.pc <= MMOA_ONCHIP_TOP);
  endsequence

  sequence s_fetch_off;
    go && (req_in.mode == MODE_FETCH) && !q.src_onchip;
  endsequence

  a_fetch_onchip: assert property (s_fetch_on |=> rsp_out.strobe.prog_int) // [RULE1]
    else $error("on-chip fetch not strobed internally");
  a_fetch_external: assert property (s_fetch_off |=> rsp_out.strobe.prog_ext) // [RULE2]
    else $error("external fetch missing");
  a_fetch_latency: assert property ((s_fetch_on or s_fetch_off) |=> rsp_out.valid) // [RULE3]
    else $error("fetch answer not one cycle later");
  a_reset_pc: assert property (@(posedge clock_in) $past(reset_in) |-> (q.pc == MMOA_RESET_PC)) // [RULE5]
    else $error("pc not zero after reset");
  a_vector_area: assert property (go && (req_in.mode == MODE_FETCH) && (q.pc == MMOA_VEC_HI) // [RULE6]
    |=> rsp_out.reserved_area) else $error("vector area not flagged");
  a_fetch_nodata: assert property (go && (req_in.mode == MODE_FETCH) // [RULE7]
    |=> !rsp_out.strobe.ext_data && !rsp_out.strobe.int_ram && !rsp_out.strobe.sfr && (q.pc == $past(q.pc) + 16'h0001))
    else $error("fetch touched data space");
  a_ext_data: assert property (go && (req_in.mode == MODE_EXT_DATA) |=> rsp_out.strobe.ext_data) // [RULE8]
    else $error("external data move not strobed");
  a_reg_bank: assert property (go && (req_in.mode == MODE_REG) // [RULE10]
    |=> rsp_out.addr[4:0] == {$past(bank), $past(req_in.opcode[2:0])}) else $error("register address wrong");
  a_direct_split: assert property (go && (req_in.mode == MODE_DIR_BYTE) // [RULE15]
    |=> rsp_out.strobe.sfr == $past(req_in.operand[7])) else $error("direct byte target wrong");
  a_bit_ram: assert property (go && (req_in.mode == MODE_DIR_BIT) && !req_in.operand[7] // [RULE16]
    |=> rsp_out.addr[7:0] == MMOA_BIT_RAM_BASE + {4'h0, $past(req_in.operand[6:3])}) else $error("ram bit byte wrong");
  a_bit_sfr: assert property (go && (req_in.mode == MODE_DIR_BIT) && req_in.operand[7] // [RULE18]
    |=> rsp_out.addr[2:0] == 3'b000) else $error("bit register not multiple of eight");
  a_call_stack: assert property (go && (req_in.mode == MODE_CALL_SAVE) // [RULE12]
    |=> sp == $past(sp) + 8'h02) else $error("call did not advance stack by two");
  a_one_strobe: assert property (rsp_out.valid |-> $onehot(rsp_out.strobe)) // [RULE21]
    else $error("strobe count not one");

endmodule : mmoa_core

// *** rtl/mmoa_pkg.sv ***
// package: address map, register layout and operand carriers of the memory map decoder
package mmoa_pkg;

  // program memory map
  localparam logic [15:0] MMOA_ONCHIP_TOP = 16'h0FFF;
  localparam logic [15:0] MMOA_RESET_PC = 16'h0000;
  localparam logic [15:0] MMOA_INIT_TOP = 16'h0002;
  localparam logic [15:0] MMOA_VEC_LO = 16'h0003;
  localparam logic [15:0] MMOA_VEC_HI = 16'h0042;
  localparam logic [15:0] MMOA_PC_STEP = 16'h0001;

  // internal data memory map
  localparam int MMOA_RAM_AW = 7;
  localparam int MMOA_RAM_DEPTH = 128;
  localparam logic [7:0] MMOA_BIT_RAM_BASE = 8'h20;
  localparam int MMOA_BANK_HI = 4;
  localparam int MMOA_BANK_LO = 3;
  localparam logic [7:0] MMOA_SP_STEP = 8'h01;

  // special function registers, one index each
  localparam int MMOA_SFR_N = 20;
  localparam logic [4:0] MMOA_I_SP = 5'h01;
  localparam logic [4:0] MMOA_I_DPL = 5'h02;
  localparam logic [4:0] MMOA_I_DPH = 5'h03;
  localparam logic [4:0] MMOA_I_PSW = 5'h11;
  localparam logic [4:0] MMOA_I_ACC = 5'h12;
  // offsets: b, acc, psw, ip, p3, ie, p2, serial_buffer, serial_control, p1, th1, th0, tl1, tl0, timer_mode_select, timer_control, dph, dpl, sp, p0
  localparam logic [MMOA_SFR_N-1:0][7:0] MMOA_SFR_ADDR = {
    8'hF0, 8'hE0, 8'hD0, 8'hB8, 8'hB0, 8'hA8, 8'hA0, 8'h99, 8'h98, 8'h90,
    8'h8D, 8'h8C, 8'h8B, 8'h8A, 8'h89, 8'h88, 8'h83, 8'h82, 8'h81, 8'h80};
  localparam logic [MMOA_SFR_N-1:0][7:0] MMOA_SFR_RST = {
    8'h00, 8'h00, 8'h00, 8'hE0, 8'hFF, 8'h60, 8'hFF, 8'h00, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'hFF};

  // operand kinds
  typedef enum logic [3:0] {
    MODE_FETCH, MODE_LOAD_PC, MODE_EXT_DATA, MODE_REG, MODE_DIR_BYTE, MODE_DIR_BIT,
    MODE_INDIRECT, MODE_BASE_INDEX, MODE_PUSH, MODE_POP, MODE_CALL_SAVE
  } mmoa_mode_e;

  typedef struct packed {
    logic prog_int;
    logic prog_ext;
    logic ext_data;
    logic int_ram;
    logic sfr;
  } mmoa_strobe_s;

  typedef struct packed {
    logic valid;
    mmoa_mode_e mode;
    logic [7:0] opcode;
    logic [7:0] operand;
    logic write;
    logic [7:0] wdata;
    logic [15:0] target;
  } mmoa_req_s;

  typedef struct packed {
    logic valid;
    mmoa_strobe_s strobe;
    logic [15:0] addr;
    logic [2:0] bitpos;
    logic [7:0] rdata;
    logic reserved_area;
  } mmoa_rsp_s;

  typedef struct packed {
    logic [2:0] sync;
    logic src_onchip;
    logic [15:0] pc;
    logic [MMOA_SFR_N-1:0][7:0] sfr;
    logic [MMOA_RAM_DEPTH-1:0][7:0] ram;
    mmoa_rsp_s rsp;
  } mmoa_state_s;

endpackage : mmoa_pkg

// *** tb/mmoa_ext_mem.sv ***
// far-side model: external program and data memories counting the accesses they receive
`timescale 1ns/100ps
module mmoa_ext_mem
  import mmoa_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // decoder answer
  input wire mmoa_rsp_s rsp_in,
  // number of external accesses seen
  output logic [15:0] ext_count_out
);
  // a fetch at 1000h is served like any other external byte
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ext_count_out <= 16'h0000;
    end else if (rsp_in.valid && (rsp_in.strobe.prog_ext || rsp_in.strobe.ext_data)) begin
      ext_count_out <= ext_count_out + 16'h0001;
    end
  end
endmodule : mmoa_ext_mem

// *** tb/tb_top.sv ***
// testbench: drives the memory map decoder and compares it with a byte model
`timescale 1ns/100ps
module tb_top
  import mmoa_pkg::*;
;
  localparam mmoa_strobe_s S_PI = 5'b10000;
  localparam mmoa_strobe_s S_PE = 5'b01000;
  localparam mmoa_strobe_s S_XD = 5'b00100;
  localparam mmoa_strobe_s S_RAM = 5'b00010;
  localparam mmoa_strobe_s S_SFR = 5'b00001;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic clk_en = 1'b1;
  logic pin = 1'b0;
  mmoa_req_s req = '0;
  mmoa_rsp_s rsp;
  logic [15:0] pc;
  logic onchip;
  logic [15:0] ext_seen;
  logic [15:0] tgt = 16'h0000;
  logic [7:0] m [256];
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] d;
  logic [31:0] seed = 32'd62359;
  logic [15:0] ra [4] = '{16'h0002, 16'h0003, 16'h0042, 16'h0043};
  int n_errors = 0;
  int compares = 0;
  int n_ext = 0;

  // clock at 5 ns
  initial begin
    forever #2.5 clock_in = ~clock_in;
  end

  mmoa_core DUT (.clock_in(clock_in), .reset_in(reset_in), .clk_en_in(clk_en),
    .program_source_select_in(pin), .req_in(req), .rsp_out(rsp),
    .program_counter_out(pc), .source_onchip_out(onchip));
  mmoa_ext_mem ext_mem (.clock_in(clock_in), .reset_in(reset_in), .rsp_in(rsp), .ext_count_out(ext_seen));

  task automatic summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  // xorshift source of stimulus
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  // one request, answer sampled one edge later
  task automatic op(input mmoa_mode_e md, input logic [7:0] opc, input logic [7:0] opd,
                    input logic wr, input logic [7:0] wd);
    @(posedge clock_in);
    #1;
    req = '{1'b1, md, opc, opd, wr, wd, tgt};
    @(posedge clock_in);
    #1;
    req.valid = 1'b0;
  endtask : op

  task automatic ex(input mmoa_strobe_s s, input logic [15:0] ad, input string msg);
    chk(rsp.valid === 1'b1 && rsp.strobe === s && rsp.addr === ad, msg);
    if (s.prog_ext || s.ext_data) begin
      n_ext++;
    end
  endtask : ex

  // direct byte write, old value returned
  task automatic wb(input logic [7:0] ad, input logic [7:0] wd);
    op(MODE_DIR_BYTE, 8'h00, ad, 1'b1, wd);
    ex(ad[7] ? S_SFR : S_RAM, {8'h00, ad}, "direct write");
    chk(rsp.rdata === m[ad], "direct old byte");
    m[ad] = wd;
  endtask : wb

  task automatic rb(input logic [7:0] ad);
    op(MODE_DIR_BYTE, 8'h00, ad, 1'b0, 8'h00);
    ex(ad[7] ? S_SFR : S_RAM, {8'h00, ad}, "direct read");
    chk(rsp.rdata === m[ad], "direct read byte");
  endtask : rb

  // hang guard
  initial begin
    #100000;
    n_errors++;
    summarize();
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      m[i] = 8'h00;
    end
    m[8'h81] = 8'h07;
    repeat (16) @(posedge clock_in);
    #1;
    reset_in = 1'b0;
    chk(pc === MMOA_RESET_PC && onchip === 1'b0, "reset pc");
    op(MODE_FETCH, 8'h00, 8'h00, 1'b0, 8'h00);
    ex(S_PE, 16'h0000, "fetch pin low");
    for (int i = 0; i < 4; i++) begin
      tgt = ra[i];
      op(MODE_LOAD_PC, 8'h00, 8'h00, 1'b0, 8'h00);
      op(MODE_FETCH, 8'h00, 8'h00, 1'b0, 8'h00);
      ex(S_PE, ra[i], "fetch pin low");
      chk(rsp.reserved_area === (ra[i] >= 16'h0003 && ra[i] <= 16'h0042), "entry area");
    end
    pin = 1'b1;
    repeat (8) @(posedge clock_in);
    #1;
    chk(onchip === 1'b1, "pin filter");
    tgt = 16'h0FFE;
    op(MODE_LOAD_PC, 8'h00, 8'h00, 1'b0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      op(MODE_FETCH, 8'h00, 8'h00, 1'b0, 8'h00);
      ex(i < 2 ? S_PI : S_PE, 16'h0FFE + 16'(i), "on-chip edge");
    end
    chk(pc === 16'h1001, "pc step");
    for (int i = 0; i < 6; i++) begin
      a = rnd();
      a[7] = 1'b0;
      wb(a, rnd());
      rb(a);
    end
    wb(8'h81, 8'h30);
    for (int bk = 0; bk < 4; bk++) begin
      wb(8'hD0, 8'(bk << 3));
      a = rnd();
      b = 8'(bk * 8) + {5'h00, a[2:0]};
      d = rnd();
      op(MODE_REG, {5'h00, a[2:0]}, 8'h00, 1'b1, d);
      ex(S_RAM, {8'h00, b}, "bank register");
      chk(rsp.rdata === m[b], "bank old byte");
      m[b] = d;
      rb(b);
    end
    op(MODE_REG, 8'h01, 8'h00, 1'b1, 8'h45);
    m[8'h19] = 8'h45;
    d = rnd();
    op(MODE_INDIRECT, 8'h01, 8'h00, 1'b1, d);
    ex(S_RAM, 16'h0045, "indirect");
    chk(rsp.rdata === m[8'h45], "indirect old byte");
    m[8'h45] = d;
    rb(8'h45);
    op(MODE_REG, 8'h00, 8'h00, 1'b1, 8'h90);
    m[8'h18] = 8'h90;
    op(MODE_INDIRECT, 8'h00, 8'h00, 1'b1, 8'h5A);
    ex(S_RAM, 16'h0090, "upper ram");
    op(MODE_INDIRECT, 8'h00, 8'h00, 1'b0, 8'h00);
    chk(rsp.rdata === 8'h00, "unpopulated ram");
    for (int i = 0; i < 5; i++) begin
      a = rnd();
      a[7] = 1'b0;
      op(MODE_DIR_BIT, 8'h00, a, 1'b1, 8'h01);
      b = 8'h20 + {4'h0, a[6:3]};
      ex(S_RAM, {8'h00, b}, "ram bit");
      chk(rsp.bitpos === a[2:0], "ram bit position");
      m[b][a[2:0]] = 1'b1;
      rb(b);
    end
    op(MODE_DIR_BIT, 8'h00, 8'h93, 1'b1, 8'h01);
    ex(S_SFR, 16'h0090, "register bit");
    chk(rsp.bitpos === 3'h3, "register bit position");
    wb(8'h82, 8'h34);
    wb(8'h83, 8'h12);
    op(MODE_EXT_DATA, 8'h00, 8'h00, 1'b0, 8'h00);
    ex(S_XD, 16'h1234, "external pointer");
    op(MODE_EXT_DATA, 8'h03, 8'h00, 1'b0, 8'h00);
    ex(S_XD, {8'h00, m[8'h19]}, "external indirect");
    op(MODE_PUSH, 8'h00, 8'h21, 1'b0, 8'h00);
    m[8'h31] = m[8'h21];
    m[8'h81] = 8'h31;
    rb(8'h81);
    rb(8'h31);
    op(MODE_POP, 8'h00, 8'h82, 1'b0, 8'h00);
    ex(S_RAM, 16'h0031, "pop");
    m[8'h82] = m[8'h31];
    m[8'h81] = 8'h30;
    rb(8'h82);
    rb(8'h81);
    op(MODE_CALL_SAVE, 8'h00, 8'h00, 1'b0, 8'h00);
    ex(S_RAM, 16'h0031, "call save");
    m[8'h31] = 8'h01;
    m[8'h32] = 8'h10;
    m[8'h81] = 8'h32;
    rb(8'h31);
    rb(8'h32);
    rb(8'h81);
    wb(8'hE0, 8'h05);
    op(MODE_BASE_INDEX, 8'h10, 8'h00, 1'b0, 8'h00);
    ex(S_PE, {8'h12, m[8'h82]} + 16'h0005, "pointer table");
    tgt = 16'h0100;
    op(MODE_LOAD_PC, 8'h00, 8'h00, 1'b0, 8'h00);
    op(MODE_BASE_INDEX, 8'h00, 8'h00, 1'b0, 8'h00);
    ex(S_PI, 16'h0105, "pc table");
    // enable low: a fetch is not taken and the answer holds
    clk_en = 1'b0;
    op(MODE_FETCH, 8'h00, 8'h00, 1'b0, 8'h00);
    chk(pc === 16'h0100 && rsp.valid === 1'b1 && rsp.addr === 16'h0105, "frozen state");
    clk_en = 1'b1;
    @(posedge clock_in);
    #1;
    chk(ext_seen === 16'(n_ext), "external count");
    summarize();
  end
endmodule : tb_top
